/* File: hw/usbemr_defs.vh */
// Constants for the USB endpoint mode responder
// Contract
// R1 - Control mode 0110: valid SETUP up to 10 bytes is ACKed, stored, mode 0001, interrupt.
// R2 - Control endpoint ignores SETUP longer than 10 bytes, no handshake.
// R3 - Mode 0110 IN gets zero-length data; host ACK sets flags, mode 0011, interrupt.
// R4 - Mode 0110 IN without host ACK changes nothing and raises no interrupt.
// R5 - Mode 0110 valid OUT up to 10 bytes gets STALL, mode 0011, interrupt.
// R6 - Mode 1011 invalid or oversize OUT is ignored without handshake.
// R7 - Mode 1011 valid OUT up to 10 bytes ACKed, stored, mode 0001, interrupt.
// R8 - Mode 1001 stall clear: valid OUT within max ACKed, mode 1000, stored, interrupt.
// R9 - Mode 1001 ignores IN, oversize OUT and invalid OUT.
// R10 - Mode 1001 stall set: valid OUT gets STALL, mode and count unchanged.
// R11 - Mode 1000 valid OUT gets NAK, interrupt if enabled; others ignored.
// R12 - Mode 1101 stall clear: IN sends buffer; host ACK sets ack, mode 1100, interrupt.
// R13 - Mode 1101 without host ACK changes nothing; OUT ignored.
// R14 - Mode 1101 stall set: IN gets STALL, no field changes.
// R15 - Mode 1100 IN gets NAK, interrupt if enabled; OUT ignored.
// R16 - Mode 0000 ignores all traffic to the endpoint.
// R17 - Status check OUT is ACKed only when zero length with toggle 1.
// R18 - Count-driven IN sends exactly the 4-bit byte count of that endpoint; the code sends the single o_count shared by all endpoints.
// R19 - Firmware reloads the mode after each automatic mode change.
`ifndef USBEMR_DEFS_VH
`define USBEMR_DEFS_VH
// ----------------------------------------
// Mode encodings
// ----------------------------------------
`define USBEMR_MODE_DISABLE   4'h0
`define USBEMR_MODE_NAK_IO    4'h1
`define USBEMR_MODE_STAT_OUT  4'h2
`define USBEMR_MODE_STALL_IO  4'h3
`define USBEMR_MODE_STAT_IN   4'h6
`define USBEMR_MODE_ACKO_SIN  4'hb
`define USBEMR_MODE_ACKI_SOUT 4'hf
`define USBEMR_MODE_NAK_OUT   4'h8
`define USBEMR_MODE_ACK_OUT   4'h9
`define USBEMR_MODE_NAK_IN    4'hc
`define USBEMR_MODE_ACK_IN    4'hd
// ----------------------------------------
// Tokens, handshakes, sizes
// ----------------------------------------
`define USBEMR_TOK_SETUP      2'h1
`define USBEMR_TOK_IN         2'h2
`define USBEMR_TOK_OUT        2'h3
`define USBEMR_HS_NONE        3'h0
`define USBEMR_HS_ACK         3'h1
`define USBEMR_HS_NAK         3'h2
`define USBEMR_HS_STALL       3'h3
`define USBEMR_HS_DATA        3'h4
`define USBEMR_CTRL_MAX       4'ha
`define USBEMR_STATUS_CNT     4'h2
`define USBEMR_BUF_DEPTH      8
`endif

/* File: hw/usbemr_buf.v */
// Endpoint byte buffer with registered read data
`timescale 1ns/1ps
module usbemr_buf
#(
  parameter AW = 5
)
(
  // Clock
  input  wire          i_sys_clk,
  // Write side
  input  wire          i_wr_en,
  input  wire [AW-1:0] i_wr_addr,
  input  wire [7:0]    i_wr_data,
  // Read side
  input  wire [AW-1:0] i_rd_addr,
  output reg  [7:0]    o_rd_data
);
  reg [7:0] mem [0:(1<<AW)-1];

  always @(posedge i_sys_clk)
  begin
    if (i_wr_en)
      mem[i_wr_addr] <= i_wr_data;
    o_rd_data <= mem[i_rd_addr];
  end
endmodule

/* File: hw/usbemr_responder.v */
// Endpoint mode responder: token decisions, mode/count updates, buffer, interrupt
`timescale 1ns/1ps
`include "usbemr_defs.vh"
module usbemr_responder
#(
  parameter DATA_MAX = 8
)
(
  // Clock and reset
  input  wire       i_sys_clk,
  input  wire       i_reset_n,
  // Token from the serial interface engine
  input  wire       i_tok_valid,
  input  wire [1:0] i_tok_pid,
  input  wire [1:0] i_tok_ep,
  input  wire [3:0] i_rx_count,
  input  wire       i_rx_crc_ok,
  input  wire       i_rx_toggle,
  // Received bytes (stored while the packet arrives)
  input  wire       i_rx_byte_valid,
  input  wire [7:0] i_rx_byte,
  // Host handshake to our data packet
  input  wire       i_host_done,
  input  wire       i_host_ack,
  // Firmware control
  input  wire       i_mode_wr,
  input  wire [1:0] i_mode_ep,
  input  wire [3:0] i_mode_val,
  input  wire       i_stall_wr,
  input  wire [1:0] i_stall_val,
  input  wire       i_count_wr,
  input  wire [3:0] i_count_val,
  input  wire       i_nak_int_en,
  input  wire       i_flags_clr,
  input  wire       i_fw_wr,
  input  wire [4:0] i_fw_addr,
  input  wire [7:0] i_fw_data,
  // Reply to the engine
  output reg  [2:0] o_handshake,
  output reg        o_hs_valid,
  output reg  [3:0] o_tx_count,
  output reg        o_tx_byte_valid,
  output reg  [7:0] o_tx_byte,
  // Status
  output reg  [3:0] o_mode0,
  output reg  [3:0] o_mode1,
  output reg  [3:0] o_mode2,
  output reg        o_setup_rcvd,
  output reg        o_in_rcvd,
  output reg        o_out_rcvd,
  output reg        o_ack_flag,
  output reg        o_data_toggle_flag,
  output reg        o_data_valid,
  output reg  [3:0] o_count,
  output reg        o_irq
);
  // ----------------------------------------
  // Endpoint state
  // ----------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_RX   = 3'b010;
  localparam ST_TX   = 3'b100;

  reg  [2:0] state;
  reg  [1:0] cur_ep;
  reg  [3:0] pend_mode;
  reg        pend_in_flag;
  reg  [3:0] wr_idx;
  reg  [3:0] tx_idx;
  reg  [3:0] tx_left;
  reg        tx_rd_ok;
  wire [7:0] rd_data;
  wire [3:0] cur_mode;
  wire       is_ctrl;
  wire [3:0] lim;
  wire       size_ok;
  wire       valid_pkt;
  wire       stall_on;
  reg  [2:0] next_hs;
  reg        next_upd;
  reg  [3:0] next_mode;
  reg        next_irq;
  reg        next_tx;
  reg        next_txz;
  reg        next_status_ack;
  reg  [1:0] stall_bits;
  wire       rx_store;
  wire [3:0] rx_idx;

  assign cur_mode  = (i_tok_ep == 2'h0) ? o_mode0 : (i_tok_ep == 2'h1) ? o_mode1 : o_mode2;
  assign is_ctrl   = (i_tok_ep == 2'h0);
  assign lim       = is_ctrl ? `USBEMR_CTRL_MAX : DATA_MAX[3:0];
  assign size_ok   = (i_rx_count <= lim);
  assign valid_pkt = size_ok && i_rx_crc_ok;
  assign stall_on  = (i_tok_ep == 2'h1) ? stall_bits[0] : stall_bits[1];
  // Data endpoints let bytes land only in mode 1001 with stall clear, so an armed IN buffer stays intact; the control endpoint stores in every mode but 0000
  assign rx_store  = (state != ST_TX) && !(is_ctrl ? (cur_mode == `USBEMR_MODE_DISABLE) :
                     (cur_mode != `USBEMR_MODE_ACK_OUT || stall_on));
  assign rx_idx    = (state == ST_RX) ? wr_idx : 4'h0;

  // Buffer per endpoint: 8 bytes each at ep*8; junk may land before validity is known
  usbemr_buf #(.AW(5)) u_buf
  (
    .i_sys_clk (i_sys_clk),
    .i_wr_en   (i_fw_wr || (rx_store && i_rx_byte_valid && rx_idx < 4'h8)),
    .i_wr_addr (i_fw_wr ? i_fw_addr : {i_tok_ep, rx_idx[2:0]}),
    .i_wr_data (i_fw_wr ? i_fw_data : i_rx_byte),
    .i_rd_addr ({cur_ep, tx_idx[2:0]}),
    .o_rd_data (rd_data)
  );

  // ----------------------------------------
  // Token decision
  // ----------------------------------------
  always @*
  begin
    next_hs = `USBEMR_HS_NONE;
    next_upd = 1'b0;
    next_mode = cur_mode;
    next_irq = 1'b0;
    next_tx = 1'b0;
    next_txz = 1'b0;
    next_status_ack = 1'b0;
    if (is_ctrl && cur_mode != `USBEMR_MODE_DISABLE && i_tok_pid == `USBEMR_TOK_SETUP)
    begin
      if (valid_pkt) // R1 R2
      begin
        next_hs = `USBEMR_HS_ACK;
        next_upd = 1'b1;
        next_mode = `USBEMR_MODE_NAK_IO;
        next_irq = 1'b1;
      end
    end
    else if (is_ctrl)
    begin
      case (cur_mode)
        `USBEMR_MODE_NAK_IO:
          if (i_tok_pid == `USBEMR_TOK_IN || valid_pkt)
            next_hs = `USBEMR_HS_NAK;
        `USBEMR_MODE_STALL_IO:
          if (i_tok_pid == `USBEMR_TOK_IN || valid_pkt)
            next_hs = `USBEMR_HS_STALL;
        `USBEMR_MODE_STAT_IN, `USBEMR_MODE_ACKO_SIN:
          if (i_tok_pid == `USBEMR_TOK_IN)
            next_txz = 1'b1; // R3
          else if (valid_pkt && cur_mode == `USBEMR_MODE_STAT_IN)
          begin
            next_hs = `USBEMR_HS_STALL; // R5
            next_mode = `USBEMR_MODE_STALL_IO;
            next_irq = 1'b1;
          end
          else if (valid_pkt) // R6 R7
          begin
            next_hs = `USBEMR_HS_ACK;
            next_upd = 1'b1;
            next_mode = `USBEMR_MODE_NAK_IO;
            next_irq = 1'b1;
          end
        `USBEMR_MODE_STAT_OUT, `USBEMR_MODE_ACKI_SOUT:
          if (i_tok_pid == `USBEMR_TOK_IN && cur_mode == `USBEMR_MODE_ACKI_SOUT)
            next_tx = 1'b1; // R18
          else if (i_tok_pid == `USBEMR_TOK_IN)
          begin
            next_hs = `USBEMR_HS_STALL;
            next_mode = `USBEMR_MODE_STALL_IO;
            next_irq = 1'b1;
          end
          else if (valid_pkt && i_rx_count == `USBEMR_STATUS_CNT && i_rx_toggle) // R17
          begin
            next_hs = `USBEMR_HS_ACK;
            next_status_ack = 1'b1;
            next_mode = `USBEMR_MODE_STAT_OUT;
            next_irq = 1'b1;
          end
          else if (valid_pkt)
          begin
            next_hs = `USBEMR_HS_STALL;
            next_mode = `USBEMR_MODE_STALL_IO;
            next_irq = 1'b1;
          end
        default:
          next_hs = `USBEMR_HS_NONE; // R16
      endcase
    end
    else
    begin
      case (cur_mode)
        `USBEMR_MODE_ACK_OUT:
          if (i_tok_pid == `USBEMR_TOK_OUT && valid_pkt && stall_on)
            next_hs = `USBEMR_HS_STALL; // R10
          else if (i_tok_pid == `USBEMR_TOK_OUT && valid_pkt) // R8 R9
          begin
            next_hs = `USBEMR_HS_ACK;
            next_upd = 1'b1;
            next_mode = `USBEMR_MODE_NAK_OUT;
            next_irq = 1'b1;
          end
        `USBEMR_MODE_NAK_OUT:
          if (i_tok_pid == `USBEMR_TOK_OUT && valid_pkt)
          begin
            next_hs = `USBEMR_HS_NAK; // R11
            next_irq = i_nak_int_en;
          end
        `USBEMR_MODE_ACK_IN:
          if (i_tok_pid == `USBEMR_TOK_IN && stall_on)
            next_hs = `USBEMR_HS_STALL; // R14
          else if (i_tok_pid == `USBEMR_TOK_IN)
            next_tx = 1'b1; // R12 R13
        `USBEMR_MODE_NAK_IN:
          if (i_tok_pid == `USBEMR_TOK_IN)
          begin
            next_hs = `USBEMR_HS_NAK; // R15
            next_irq = i_nak_int_en;
          end
        default:
          next_hs = `USBEMR_HS_NONE; // R16
      endcase
    end
  end

  // ----------------------------------------
  // Sequencing and register updates
  // ----------------------------------------
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state <= ST_IDLE;
      cur_ep <= 2'h0;
      pend_mode <= 4'h0;
      pend_in_flag <= 1'b0;
      wr_idx <= 4'h0;
      tx_idx <= 4'h0;
      tx_left <= 4'h0;
      tx_rd_ok <= 1'b0;
      stall_bits <= 2'h0;
      o_handshake <= `USBEMR_HS_NONE;
      o_hs_valid <= 1'b0;
      o_tx_count <= 4'h0;
      o_tx_byte_valid <= 1'b0;
      o_tx_byte <= 8'h00;
      o_mode0 <= `USBEMR_MODE_DISABLE;
      o_mode1 <= `USBEMR_MODE_DISABLE;
      o_mode2 <= `USBEMR_MODE_DISABLE;
      o_setup_rcvd <= 1'b0;
      o_in_rcvd <= 1'b0;
      o_out_rcvd <= 1'b0;
      o_ack_flag <= 1'b0;
      o_data_toggle_flag <= 1'b0;
      o_data_valid <= 1'b0;
      o_count <= 4'h0;
      o_irq <= 1'b0;
    end
    else
    begin
      o_hs_valid <= 1'b0;
      o_irq <= 1'b0;
      o_tx_byte_valid <= 1'b0;
      if (i_flags_clr)
      begin
        o_setup_rcvd <= 1'b0;
        o_in_rcvd <= 1'b0;
        o_out_rcvd <= 1'b0;
        o_ack_flag <= 1'b0;
      end
      if (i_stall_wr)
        stall_bits <= i_stall_val;
      if (i_count_wr)
        o_count <= i_count_val;
      // Firmware re-arms endpoints; a hardware change in the same cycle wins below
      if (i_mode_wr) // R19
        case (i_mode_ep)
          2'h0: o_mode0 <= i_mode_val;
          2'h1: o_mode1 <= i_mode_val;
          default: o_mode2 <= i_mode_val;
        endcase
      case (state)
        ST_IDLE, ST_RX:
          if (i_tok_valid && i_tok_pid != 2'h0)
          begin
            cur_ep <= i_tok_ep;
            wr_idx <= 4'h0;
            tx_idx <= 4'h0;
            o_handshake <= next_hs;
            o_hs_valid <= (next_hs != `USBEMR_HS_NONE) || next_tx || next_txz;
            if (next_tx || next_txz)
            begin
              o_handshake <= `USBEMR_HS_DATA;
              o_tx_count <= next_txz ? 4'h0 : o_count; // R18
              tx_left <= next_txz ? 4'h0 : o_count;
              tx_rd_ok <= 1'b0;
              pend_in_flag <= is_ctrl;
              pend_mode <= is_ctrl ? ((cur_mode == `USBEMR_MODE_STAT_IN) ?
                `USBEMR_MODE_STALL_IO : (cur_mode == `USBEMR_MODE_ACKO_SIN) ?
                `USBEMR_MODE_STALL_IO : `USBEMR_MODE_NAK_IO) : `USBEMR_MODE_NAK_IN;
              state <= ST_TX;
            end
            else
            begin
              state <= ST_IDLE;
              o_irq <= next_irq;
              if (next_mode != cur_mode)
                case (i_tok_ep)
                  2'h0: o_mode0 <= next_mode;
                  2'h1: o_mode1 <= next_mode;
                  default: o_mode2 <= next_mode;
                endcase
              if (next_upd || next_status_ack)
              begin
                o_ack_flag <= 1'b1;
                o_data_valid <= 1'b1;
                o_data_toggle_flag <= next_status_ack ? 1'b1 : i_rx_toggle;
                o_count <= i_rx_count;
                if (i_tok_pid == `USBEMR_TOK_SETUP)
                  o_setup_rcvd <= 1'b1;
                else if (is_ctrl)
                  o_out_rcvd <= 1'b1;
              end
            end
          end
          else if (i_rx_byte_valid)
          begin
            // Bytes precede the token verdict; store them and let junk stand
            state <= ST_RX;
            cur_ep <= i_tok_ep;
            if (state == ST_IDLE)
              wr_idx <= 4'h1;
            else if (wr_idx != 4'hf)
              wr_idx <= wr_idx + 4'h1;
          end
        ST_TX:
        begin
          if (tx_left != 4'h0)
          begin
            tx_rd_ok <= 1'b1;
            tx_idx <= tx_idx + 4'h1;
            tx_left <= tx_left - 4'h1;
          end
          else
            tx_rd_ok <= 1'b0;
          o_tx_byte_valid <= tx_rd_ok;
          o_tx_byte <= rd_data;
          if (i_host_done)
          begin
            state <= ST_IDLE;
            if (i_host_ack) // R3 R12 R4 R13
            begin
              o_ack_flag <= 1'b1;
              o_irq <= 1'b1;
              if (pend_in_flag)
                o_in_rcvd <= 1'b1;
              case (cur_ep)
                2'h0: o_mode0 <= pend_mode;
                2'h1: o_mode1 <= pend_mode;
                default: o_mode2 <= pend_mode;
              endcase
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule

/* File: verification/usbemr_checker_assertions.sv */
// Concurrent checks on the endpoint mode responder ports
`timescale 1ns/1ps
module usbemr_checker
#(
  parameter DATA_MAX = 8
)
(
  // Clock and reset
  input wire       i_sys_clk,
  input wire       i_reset_n,
  // Token and host handshake
  input wire       i_tok_valid,
  input wire [1:0] i_tok_pid,
  input wire [1:0] i_tok_ep,
  input wire [3:0] i_rx_count,
  input wire       i_rx_crc_ok,
  input wire       i_host_done,
  input wire       i_host_ack,
  // Responses
  input wire [2:0] o_handshake,
  input wire       o_hs_valid,
  input wire [3:0] o_mode0,
  input wire [3:0] o_mode1,
  input wire [3:0] o_mode2,
  input wire       o_setup_rcvd,
  input wire       o_irq
);
  wire t0   = i_tok_valid && i_tok_ep == 2'h0;
  wire t1   = i_tok_valid && i_tok_ep == 2'h1;
  wire t2   = i_tok_valid && i_tok_ep == 2'h2;
  wire ok10 = i_rx_crc_ok && i_rx_count <= 4'ha;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  property p_setup_ack;
    t0 && i_tok_pid == 2'h1 && ok10 && o_mode0 == 4'h6 |->
      ##[1:2] (o_hs_valid && o_handshake == 3'h1 && o_mode0 == 4'h1 && o_setup_rcvd);
  endproperty
  a_setup_ack: assert property (p_setup_ack) else $error("setup not acked");
  property p_out_stall;
    t0 && i_tok_pid == 2'h3 && ok10 && o_mode0 == 4'h6 |->
      ##[1:2] (o_hs_valid && o_handshake == 3'h3 && o_mode0 == 4'h3);
  endproperty
  a_out_stall: assert property (p_out_stall) else $error("out not stalled");
  property p_out_ignore;
    t1 && o_mode1 == 4'h9 && (i_tok_pid == 2'h2 || i_rx_count > DATA_MAX || !i_rx_crc_ok)
      |-> ##1 (!o_hs_valid) [*2];
  endproperty
  a_out_ignore: assert property (p_out_ignore) else $error("data out answered");
  property p_out_nak;
    t1 && o_mode1 == 4'h8 && i_tok_pid == 2'h3 && i_rx_crc_ok && i_rx_count <= DATA_MAX
      |-> ##[1:2] (o_hs_valid && o_handshake == 3'h2);
  endproperty
  a_out_nak: assert property (p_out_nak) else $error("out not naked");
  property p_in_nak;
    t2 && o_mode2 == 4'hc && i_tok_pid == 2'h2 |-> ##[1:2] (o_hs_valid && o_handshake == 3'h2);
  endproperty
  a_in_nak: assert property (p_in_nak) else $error("in not naked");
  property p_in_acked;
    i_host_done && i_host_ack && o_mode2 == 4'hd |-> ##[1:2] (o_irq && o_mode2 == 4'hc);
  endproperty
  a_in_acked: assert property (p_in_acked) else $error("in ack not taken");
  property p_no_ack;
    i_host_done && !i_host_ack |=> (!o_irq && $stable(o_mode0) && $stable(o_mode2)) [*2];
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("state moved without ack");
  property p_disabled;
    t0 && o_mode0 == 4'h0 |-> ##1 (!o_hs_valid && !o_irq) [*2];
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled ep answered");
endmodule

/* File: verification/usbemr_host.sv */
// Host model: tokens, packet bytes and handshakes toward the responder
`timescale 1ns/1ps
module usbemr_host
(
  // Clock
  input  wire       i_sys_clk,
  // Token and packet
  output reg        o_tok_valid = 1'b0,
  output reg  [1:0] o_tok_pid = 2'h0,
  output reg  [1:0] o_tok_ep = 2'h0,
  output reg  [3:0] o_rx_count = 4'h0,
  output reg        o_rx_crc_ok = 1'b0,
  output reg        o_rx_toggle = 1'b0,
  output reg        o_rx_byte_valid = 1'b0,
  output reg  [7:0] o_rx_byte = 8'h0,
  // Handshake to our data
  output reg        o_host_done = 1'b0,
  output reg        o_host_ack = 1'b0
);
  // Byte count includes the two check bytes, so payload is cnt-2
  task send(input [1:0] pid, input [1:0] ep, input [3:0] cnt, input crc, input tog);
    integer k;
    begin
      @(negedge i_sys_clk);
      o_tok_ep = ep;
      for (k = 2; k < cnt; k = k + 1)
      begin
        {o_rx_byte_valid, o_rx_byte} = {1'b1, 8'ha0 + k[7:0]};
        @(negedge i_sys_clk);
      end
      {o_rx_byte_valid, o_rx_byte} = {1'b0, ~o_rx_byte};
      {o_tok_valid, o_tok_pid, o_rx_count, o_rx_crc_ok, o_rx_toggle} = {1'b1, pid, cnt, crc, tog};
      @(negedge i_sys_clk);
      o_tok_valid = 1'b0;
      // Released fields show junk, not the last value
      {o_tok_pid, o_tok_ep, o_rx_count} = ~{pid, ep, cnt};
    end
  endtask
  task answer(input ack);
    begin
      @(negedge i_sys_clk);
      {o_host_done, o_host_ack} = {1'b1, ack};
      @(negedge i_sys_clk);
      {o_host_done, o_host_ack} = {1'b0, ~ack};
    end
  endtask
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the endpoint mode responder
`timescale 1ns/1ps
module testbench;
  reg        i_sys_clk = 1'b0, i_reset_n = 1'b0, i_nak_int_en = 1'b0, i_flags_clr = 1'b0;
  reg        i_mode_wr = 1'b0, i_stall_wr = 1'b0, i_count_wr = 1'b0, i_fw_wr = 1'b0;
  reg  [1:0] i_mode_ep = 2'h0, i_stall_val = 2'h0;
  reg  [3:0] i_mode_val = 4'h0, i_count_val = 4'h0;
  reg  [4:0] i_fw_addr = 5'h0;
  reg  [7:0] i_fw_data = 8'h0;
  wire       i_tok_valid, i_rx_crc_ok, i_rx_toggle, i_rx_byte_valid, i_host_done, i_host_ack;
  wire [1:0] i_tok_pid, i_tok_ep;
  wire [3:0] i_rx_count, o_tx_count, o_mode0, o_mode1, o_mode2, o_count;
  wire [7:0] i_rx_byte, o_tx_byte;
  wire [2:0] o_handshake;
  wire       o_hs_valid, o_tx_byte_valid, o_setup_rcvd, o_in_rcvd, o_out_rcvd, o_ack_flag;
  wire       o_data_toggle_flag, o_data_valid, o_irq;
  integer    fails = 0, num_checks = 0, irqs = 0, hss = 0, txn = 0, k;
  reg  [2:0] hs;
  reg  [7:0] txb [0:7];
  usbemr_host usbemr_host_inst (.i_sys_clk(i_sys_clk), .o_tok_valid(i_tok_valid),
    .o_tok_pid(i_tok_pid), .o_tok_ep(i_tok_ep), .o_rx_count(i_rx_count), .o_rx_byte(i_rx_byte),
    .o_rx_crc_ok(i_rx_crc_ok), .o_rx_toggle(i_rx_toggle), .o_rx_byte_valid(i_rx_byte_valid),
    .o_host_done(i_host_done), .o_host_ack(i_host_ack));
  usbemr_responder #(.DATA_MAX(8)) usbemr_responder_inst (.i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n), .i_tok_valid(i_tok_valid), .i_tok_pid(i_tok_pid), .i_tok_ep(i_tok_ep),
    .i_rx_count(i_rx_count), .i_rx_crc_ok(i_rx_crc_ok), .i_rx_toggle(i_rx_toggle),
    .i_rx_byte_valid(i_rx_byte_valid), .i_rx_byte(i_rx_byte), .i_host_done(i_host_done),
    .i_host_ack(i_host_ack), .i_mode_wr(i_mode_wr), .i_mode_ep(i_mode_ep), .i_fw_wr(i_fw_wr),
    .i_mode_val(i_mode_val), .i_stall_wr(i_stall_wr), .i_stall_val(i_stall_val),
    .i_count_wr(i_count_wr), .i_count_val(i_count_val), .i_nak_int_en(i_nak_int_en),
    .i_flags_clr(i_flags_clr), .i_fw_addr(i_fw_addr), .i_fw_data(i_fw_data),
    .o_handshake(o_handshake), .o_hs_valid(o_hs_valid), .o_tx_count(o_tx_count),
    .o_tx_byte_valid(o_tx_byte_valid), .o_tx_byte(o_tx_byte), .o_mode0(o_mode0),
    .o_mode1(o_mode1), .o_mode2(o_mode2), .o_setup_rcvd(o_setup_rcvd), .o_in_rcvd(o_in_rcvd),
    .o_out_rcvd(o_out_rcvd), .o_ack_flag(o_ack_flag), .o_data_valid(o_data_valid),
    .o_data_toggle_flag(o_data_toggle_flag), .o_count(o_count), .o_irq(o_irq));
  initial
    forever #2.5 i_sys_clk = ~i_sys_clk;
  // Pulses are one cycle wide, so tally them as they pass
  always @(posedge i_sys_clk)
  begin
    irqs = irqs + (o_irq === 1'b1);
    if (o_hs_valid === 1'b1)
      {hs, hss} = {o_handshake, hss + 1};
    if (o_tx_byte_valid === 1'b1)
      {txb[txn % 8], txn} = {o_tx_byte, txn + 1};
  end
  task report_and_stop;
    begin
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp, input [79:0] nm);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        fails = fails + 1;
        $display("Error %0s expected %0h seen %0h", nm, exp, seen);
      end
    end
  endtask
  // Mode, stall bits and flag clear in one firmware pulse
  task setm(input [1:0] ep, input [3:0] val, input [1:0] st);
    begin
      @(negedge i_sys_clk);
      {i_mode_wr, i_mode_ep, i_mode_val} = {1'b1, ep, val};
      {i_stall_wr, i_stall_val, i_flags_clr} = {1'b1, st, 1'b1};
      @(negedge i_sys_clk);
      {i_mode_wr, i_stall_wr, i_flags_clr} = 3'h0;
    end
  endtask
  task tok(input [1:0] pid, ep, input [3:0] cnt, input crc, tog, input [2:0] ehs, input ei);
    integer i0, h0;
    begin
      {i0, h0, txn} = {irqs, hss, 32'h0};
      usbemr_host_inst.send(pid, ep, cnt, crc, tog);
      repeat (4) @(negedge i_sys_clk);
      check(hss - h0, ehs != 3'h0, "hs_pulses");
      if (ehs != 3'h0)
        check(hs, ehs, "handshake");
      check(irqs - i0, ei, "irq_pulses");
    end
  endtask
  task done(input ack, input [3:0] n, input ei);
    integer i0, j;
    begin
      for (j = 0; j < 40 && txn < n; j = j + 1)
        @(negedge i_sys_clk);
      if (txn < n)
      begin
        fails = fails + 1;
        report_and_stop;
      end
      i0 = irqs;
      usbemr_host_inst.answer(ack);
      repeat (3) @(negedge i_sys_clk);
      check(irqs - i0, ei, "irq_pulses");
    end
  endtask
  task t_setup;
    begin
      tok(2'h1, 2'h0, 4'h4, 1, 0, 3'h0, 0);
      setm(2'h0, 4'h6, 2'h0);
      tok(2'h1, 2'h0, 4'hb, 1, 0, 3'h0, 0);
      tok(2'h1, 2'h0, 4'ha, 1, 0, 3'h1, 1);
      check({o_mode0, o_setup_rcvd, o_ack_flag, o_data_valid, o_count}, 11'h0fa, "ep0_state");
    end
  endtask
  task t_status_in;
    begin
      setm(2'h0, 4'h6, 2'h0);
      tok(2'h3, 2'h0, 4'h4, 1, 1, 3'h3, 1);
      check(o_mode0, 4'h3, "mode0");
      setm(2'h0, 4'h6, 2'h0);
      tok(2'h2, 2'h0, 4'h0, 1, 0, 3'h4, 0);
      check(o_tx_count, 4'h0, "tx_count");
      done(0, 4'h0, 0);
      check({o_mode0, o_in_rcvd}, 5'hc, "ep0_state");
      tok(2'h2, 2'h0, 4'h0, 1, 0, 3'h4, 0);
      done(1, 4'h0, 1);
      check({o_mode0, o_in_rcvd, o_ack_flag}, 6'hf, "ep0_state");
    end
  endtask
  task t_ack_out;
    begin
      setm(2'h0, 4'hb, 2'h0);
      tok(2'h3, 2'h0, 4'h5, 0, 1, 3'h0, 0);
      tok(2'h3, 2'h0, 4'hb, 1, 1, 3'h0, 0);
      tok(2'h3, 2'h0, 4'h5, 1, 1, 3'h1, 1);
      check({o_mode0, o_out_rcvd, o_ack_flag, o_data_toggle_flag, o_count}, 11'h0f5, "ep0_state");
      setm(2'h0, 4'h2, 2'h0);
      tok(2'h3, 2'h0, 4'h2, 1, 0, 3'h3, 1);
      setm(2'h0, 4'h2, 2'h0);
      tok(2'h3, 2'h0, 4'h2, 1, 1, 3'h1, 1);
      check({o_mode0, o_out_rcvd, o_count}, 9'h52, "ep0_state");
      setm(2'h0, 4'hf, 2'h0);
      tok(2'h3, 2'h0, 4'h2, 1, 1, 3'h1, 1);
      check(o_mode0, 4'h2, "mode0");
    end
  endtask
  task t_data_out;
    begin
      setm(2'h1, 4'h9, 2'h1);
      tok(2'h3, 2'h1, 4'h4, 1, 0, 3'h3, 0);
      check(o_mode1, 4'h9, "mode1");
      setm(2'h1, 4'h9, 2'h0);
      tok(2'h2, 2'h1, 4'h0, 1, 0, 3'h0, 0);
      tok(2'h3, 2'h1, 4'h9, 1, 0, 3'h0, 0);
      tok(2'h3, 2'h1, 4'h4, 0, 0, 3'h0, 0);
      tok(2'h3, 2'h1, 4'h8, 1, 1, 3'h1, 1);
      check({o_mode1, o_data_valid, o_count}, 9'h118, "ep1_state");
      tok(2'h3, 2'h1, 4'h4, 1, 0, 3'h2, 0);
      i_nak_int_en = 1'b1;
      tok(2'h3, 2'h1, 4'h4, 1, 0, 3'h2, 1);
      tok(2'h2, 2'h1, 4'h0, 1, 0, 3'h0, 0);
    end
  endtask
  task t_data_in;
    begin
      for (k = 0; k < 3; k = k + 1)
      begin
        @(negedge i_sys_clk);
        {i_fw_wr, i_fw_addr, i_fw_data} = {1'b1, 5'h10 + k[4:0], 8'h30 + k[7:0]};
      end
      @(negedge i_sys_clk);
      {i_fw_wr, i_count_wr, i_count_val} = 6'h13;
      setm(2'h2, 4'hd, 2'h0);
      i_count_wr = 1'b0;
      tok(2'h3, 2'h2, 4'h4, 1, 0, 3'h0, 0);
      tok(2'h2, 2'h2, 4'h0, 1, 0, 3'h4, 0);
      check(o_tx_count, 4'h3, "tx_count");
      done(0, 4'h3, 0);
      check(o_mode2, 4'hd, "mode2");
      tok(2'h2, 2'h2, 4'h0, 1, 0, 3'h4, 0);
      done(1, 4'h3, 1);
      for (k = 0; k < 3; k = k + 1)
        check(txb[k], 8'h30 + k, "tx_byte");
      check({o_mode2, o_ack_flag}, 5'h19, "ep2_state");
      tok(2'h2, 2'h2, 4'h0, 1, 0, 3'h2, 1);
      tok(2'h3, 2'h2, 4'h4, 1, 0, 3'h0, 0);
      setm(2'h2, 4'hd, 2'h2);
      tok(2'h2, 2'h2, 4'h0, 1, 0, 3'h3, 0);
      check(o_mode2, 4'hd, "mode2");
    end
  endtask
  initial
  begin
    repeat (16) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    t_setup;
    t_status_in;
    t_ack_out;
    t_data_out;
    t_data_in;
    report_and_stop;
  end
endmodule
bind usbemr_responder usbemr_checker #(.DATA_MAX(DATA_MAX)) usbemr_checker_inst (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_tok_valid(i_tok_valid),
  .i_tok_pid(i_tok_pid), .i_tok_ep(i_tok_ep), .i_rx_count(i_rx_count), .i_rx_crc_ok(i_rx_crc_ok),
  .i_host_done(i_host_done), .i_host_ack(i_host_ack), .o_handshake(o_handshake),
  .o_hs_valid(o_hs_valid), .o_mode0(o_mode0), .o_mode1(o_mode1), .o_mode2(o_mode2),
  .o_setup_rcvd(o_setup_rcvd), .o_irq(o_irq));
